/* logic/cbt_pkg.sv */
// Package for the command bus training block: mode addresses, fields, timing.
// Assumes a 40 MHz command clock; delay figures are in nanoseconds, the clock period in picoseconds.
package cbt_pkg;

  // ----------------------------------------------------------------
  // Mode register addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] CBT_ADDR_CMD_REF = 6'h0C;
  localparam logic [5:0] CBT_ADDR_MODE_CTRL = 6'h0D;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int CBT_BIT_TRAIN_EN = 0;
  localparam int CBT_BIT_WR_SEL = 6;
  localparam int CBT_BIT_OP_SEL = 7;
  localparam int CBT_REF_W = 7;
  localparam int CBT_ECHO_LO = 8;
  localparam int CBT_ECHO_HI = 13;
  localparam logic [7:0] CBT_MODE_RESET = 8'h00;
  localparam logic [6:0] CBT_REF_RESET = 7'h00;
  localparam logic CBT_BANK_POWERUP = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CBT_CLK_PERIOD_PS = 25000;
  localparam int CBT_PS_PER_NS = 1000;
  localparam int CBT_CNT_W = 8;

  function automatic logic [CBT_CNT_W-1:0] cbt_cycles(input int ns);
    int c;
    c = (ns * CBT_PS_PER_NS + CBT_CLK_PERIOD_PS - 1) / CBT_CLK_PERIOD_PS;
    if (c < 1) begin
      c = 1;
    end
    return c[CBT_CNT_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CBT_IDLE = 3'b000,
    CBT_ARMED = 3'b001,
    CBT_TRAIN = 3'b010,
    CBT_EXIT = 3'b011,
    CBT_RECOVER = 3'b100
  } cbt_state_type;

  typedef struct packed {
    logic valid;
    logic [5:0] addr;
    logic [7:0] data;
  } cbt_mode_write_type;

  typedef struct packed {
    logic [15:0] data;
    logic [15:0] oe_n;
  } cbt_dq_drive_type;

endpackage

/* logic/cbt_core.sv */
// Command bus training logic inside the memory device.
// Assumes mode writes arrive decoded on the command clock; strobes and data
// lines come from outside and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module cbt_core
  import cbt_pkg::*;
#(
  parameter int MODE_WRITE_DELAY_NS = 20,
  parameter int TRAINING_ENTRY_DELAY_NS = 250,
  parameter int MODE_WRITE_RECOVERY_NS = 20
) (
  // Clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Command side
  input wire logic cke_in,
  input wire logic cs_in,
  input wire logic [5:0] command_address_bus_in,
  input wire cbt_mode_write_type mode_write_in,
  // Data lines and strobes
  input wire logic dqs_t_in,
  input wire logic dqs_c_in,
  input wire logic [15:0] dq_in,
  output cbt_dq_drive_type dq_drive_out,
  // Status
  output logic training_out,
  output logic ready_out,
  output logic active_setpoint_bank_out,
  output logic [7:0] mode_control_register_out,
  output logic [6:0] command_input_reference_out
);

  localparam logic [CBT_CNT_W-1:0] MRD_CYC = cbt_cycles(MODE_WRITE_DELAY_NS);
  localparam logic [CBT_CNT_W-1:0] CAENT_CYC = cbt_cycles(TRAINING_ENTRY_DELAY_NS);
  localparam logic [CBT_CNT_W-1:0] MRW_CYC = cbt_cycles(MODE_WRITE_RECOVERY_NS);
  localparam logic [CBT_CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CBT_CNT_W-1:0] CNT_ONE = CBT_CNT_W'(1);

  cbt_state_type state;
  logic [CBT_CNT_W-1:0] cnt;
  logic [7:0] mode_ctrl;
  logic [6:0] ref_bank [2];
  logic [6:0] ref_temp;
  logic [5:0] ca_latch;
  logic dqs_t_s1, dqs_t_s2, dqs_c_s1, dqs_c_s2, strobe_d;
  logic [6:0] dq_s1, dq_s2;
  logic strobe, strobe_edge, wr_mode, wr_ref, capture_ok;
  logic bank_before;

  // ----------------------------------------------------------------
  // Synchronisers and strobe edges
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      dqs_t_s1 <= 1'b0;
      dqs_t_s2 <= 1'b0;
      dqs_c_s1 <= 1'b1;
      dqs_c_s2 <= 1'b1;
      dq_s1 <= '0;
      dq_s2 <= '0;
      strobe_d <= 1'b0;
    end else if (ce_in) begin
      dqs_t_s1 <= dqs_t_in;
      dqs_t_s2 <= dqs_t_s1;
      dqs_c_s1 <= dqs_c_in;
      dqs_c_s2 <= dqs_c_s1;
      dq_s1 <= dq_in[CBT_REF_W-1:0];
      dq_s2 <= dq_s1;
      strobe_d <= strobe;
    end
  end

  assign strobe = dqs_t_s2 & ~dqs_c_s2;
  assign strobe_edge = ce_in & (strobe != strobe_d);
  assign wr_mode = ce_in & mode_write_in.valid & (mode_write_in.addr == CBT_ADDR_MODE_CTRL);
  assign wr_ref = ce_in & mode_write_in.valid & (mode_write_in.addr == CBT_ADDR_CMD_REF);
  assign capture_ok = (state == CBT_TRAIN) && (cnt == CNT_ZERO);

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      mode_ctrl <= CBT_MODE_RESET;
      ref_bank[0] <= CBT_REF_RESET;
      ref_bank[1] <= CBT_REF_RESET;
    end else begin
      if (wr_mode) begin
        mode_ctrl <= mode_write_in.data;
      end
      if (wr_ref) begin
        ref_bank[mode_ctrl[CBT_BIT_WR_SEL]] <= mode_write_in.data[CBT_REF_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Training sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state <= CBT_IDLE;
      cnt <= CNT_ZERO;
    end else if (ce_in) begin
      if (cnt != CNT_ZERO) begin
        cnt <= cnt - CNT_ONE;
      end
      case (state)
        CBT_IDLE: begin
          if (wr_mode && mode_write_in.data[CBT_BIT_TRAIN_EN] && cke_in) begin
            state <= CBT_ARMED;
            cnt <= MRD_CYC;
          end
        end
        CBT_ARMED: begin
          if (wr_mode && !mode_write_in.data[CBT_BIT_TRAIN_EN]) begin
            state <= CBT_IDLE;
          end else if (!cke_in && cnt == CNT_ZERO) begin
            state <= CBT_TRAIN;
            cnt <= CAENT_CYC;
          end
        end
        CBT_TRAIN: begin
          if (cke_in) begin
            state <= CBT_EXIT;
          end
        end
        CBT_EXIT: begin
          if (wr_mode && !mode_write_in.data[CBT_BIT_TRAIN_EN]) begin
            state <= CBT_RECOVER;
            cnt <= MRW_CYC;
          end
        end
        CBT_RECOVER: begin
          if (cnt == CNT_ZERO) begin
            state <= CBT_IDLE;
          end
        end
        default: begin
          state <= CBT_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Temporary reference and command/address echo
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ref_temp <= CBT_REF_RESET;
    end else if (ce_in) begin
      if (state == CBT_ARMED) begin
        ref_temp <= ref_bank[~mode_ctrl[CBT_BIT_OP_SEL]];
      end else if (capture_ok && strobe_edge) begin
        ref_temp <= dq_s2;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ca_latch <= '0;
    end else if (ce_in && cs_in) begin
      ca_latch <= command_address_bus_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      dq_drive_out <= '{data: '0, oe_n: '1};
    end else if (ce_in) begin
      dq_drive_out.data <= '0;
      dq_drive_out.oe_n <= '1;
      if (state == CBT_TRAIN) begin
        dq_drive_out.data[CBT_ECHO_HI:CBT_ECHO_LO] <= ca_latch;
        dq_drive_out.oe_n[CBT_ECHO_HI:CBT_ECHO_LO] <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  assign training_out = (state == CBT_TRAIN);
  assign ready_out = (state == CBT_IDLE);
  assign active_setpoint_bank_out = training_out ? ~mode_ctrl[CBT_BIT_OP_SEL]
                                                 : mode_ctrl[CBT_BIT_OP_SEL];
  assign mode_control_register_out = mode_ctrl;
  assign command_input_reference_out = training_out ? ref_temp
                                                    : ref_bank[active_setpoint_bank_out];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Bank in use before training, held while training
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      bank_before <= CBT_BANK_POWERUP;
    end else if (ce_in && !training_out) begin
      bank_before <= active_setpoint_bank_out;
    end
  end

  powerup_bank_a: assert property (@(posedge clk_sys_in)
    !rstn_in |=> active_setpoint_bank_out == CBT_BANK_POWERUP)
    else $error("bank not zero after reset");

  entry_cke_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    $rose(training_out) |-> $past(!cke_in) && $past(state == CBT_ARMED))
    else $error("training entered without clock enable low");

  entry_bank_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    training_out |-> active_setpoint_bank_out != bank_before)
    else $error("training not on alternate bank");

  exit_bank_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    $fell(training_out) |-> active_setpoint_bank_out == bank_before)
    else $error("bank not restored on exit");

  echo_map_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ce_in && training_out && $past(training_out) |=>
      dq_drive_out.data[CBT_ECHO_HI:CBT_ECHO_LO] == $past(ca_latch)
      && dq_drive_out.oe_n[CBT_ECHO_HI:CBT_ECHO_LO] == '0)
    else $error("echo lines wrong");

  idle_lines_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    dq_drive_out.oe_n[15:14] == '1 && dq_drive_out.oe_n[7:0] == '1)
    else $error("unused lines driven");

  capture_map_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    capture_ok && strobe_edge |=> ref_temp == $past(dq_s2))
    else $error("reference not loaded from lines");

  no_early_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    training_out && cnt != CNT_ZERO && state != CBT_ARMED |=> $stable(ref_temp))
    else $error("reference changed before entry delay");

  recovery_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ce_in && state == CBT_EXIT && wr_mode && !mode_write_in.data[CBT_BIT_TRAIN_EN]
      |=> !ready_out [*2])
    else $error("ready before recovery time");

endmodule
`default_nettype wire

/* bench/cbt_ctl_model.sv */
// Controller-side partner of the command bus training block.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module cbt_ctl_model
  import cbt_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  // Command side
  output logic cke_out,
  output logic cs_out,
  output logic [5:0] cmd_addr_out,
  output cbt_mode_write_type mw_out,
  // Strobes and data lines
  output logic dqs_t_out,
  output logic dqs_c_out,
  output logic [15:0] dq_out
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    cke_out = 1'b1;
    cs_out = 1'b0;
    cmd_addr_out = 6'h00;
    mw_out = '0;
    dqs_t_out = 1'b0;
    dqs_c_out = 1'b1;
    dq_out = 16'h0000;
  end

  // Unused lines keep changing
  always @(posedge clk_sys_in) dq_out[15:7] <= ~dq_out[15:7];

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic mwr(input logic [5:0] a, input logic [7:0] d);
    mw_out <= '{valid: 1'b1, addr: a, data: d};
    @(posedge clk_sys_in);
    mw_out.valid <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic vref(input logic [6:0] code);
    dq_out[6:0] <= code;
    repeat (4) begin
      repeat (4) @(posedge clk_sys_in);
      dqs_t_out <= ~dqs_t_out;
      dqs_c_out <= ~dqs_c_out;
    end
    repeat (12) @(posedge clk_sys_in);
  endtask
endmodule
`default_nettype wire

/* bench/tb_command_bus_training_mode.sv */
// Self-checking bench of the command bus training block.
// Assumes cbt_pkg and the controller partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_command_bus_training_mode;
  import cbt_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce = 1'b1;
  logic cke, cs, dqs_t, dqs_c, training, ready, bank;
  logic [5:0] cmd_addr;
  logic [15:0] dq;
  logic [7:0] mode;
  logic [6:0] cref;
  cbt_mode_write_type mw;
  cbt_dq_drive_type drv;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int m_ref [2];
  int codes[$];
  logic [5:0] m_echo;
  logic [15:0] seed = 16'h6fcd;

  always #12.5 clk_sys_in = ~clk_sys_in;

  cbt_ctl_model ctl (.clk_sys_in(clk_sys_in), .cke_out(cke), .cs_out(cs),
    .cmd_addr_out(cmd_addr), .mw_out(mw), .dqs_t_out(dqs_t), .dqs_c_out(dqs_c), .dq_out(dq));
  cbt_core #(.MODE_WRITE_DELAY_NS(20), .TRAINING_ENTRY_DELAY_NS(250),
    .MODE_WRITE_RECOVERY_NS(20)) dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .ce_in(ce), .cke_in(cke), .cs_in(cs), .command_address_bus_in(cmd_addr),
    .mode_write_in(mw), .dqs_t_in(dqs_t), .dqs_c_in(dqs_c), .dq_in(dq),
    .dq_drive_out(drv), .training_out(training), .ready_out(ready),
    .active_setpoint_bank_out(bank), .mode_control_register_out(mode),
    .command_input_reference_out(cref));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  task automatic finish_test;
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    chk("bank", 16'(0), 16'(bank));
    chk("ready", 16'(1), 16'(ready));
    chk("oe_n", 16'hffff, drv.oe_n);
    @(posedge clk_sys_in);
    ce <= 1'b0;
    ctl.mwr(CBT_ADDR_MODE_CTRL, 8'h41);
    ce <= 1'b1;
    #1;
    chk("mode", 16'h0000, 16'(mode));
    chk("ready", 16'(1), 16'(ready));
    @(posedge clk_sys_in);
    ctl.mwr(CBT_ADDR_MODE_CTRL, 8'h41);
    #1;
    chk("ready", 16'(0), 16'(ready));
    @(posedge clk_sys_in);
    ctl.mwr(CBT_ADDR_MODE_CTRL, 8'h40);
    ctl.cke_out <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk("training", 16'(0), 16'(training));
    chk("ready", 16'(1), 16'(ready));
    @(posedge clk_sys_in);
    ctl.cke_out <= 1'b1;
    @(posedge clk_sys_in);
    for (int b = 0; b < 2; b++) begin
      ctl.mwr(CBT_ADDR_MODE_CTRL, 8'(b << CBT_BIT_WR_SEL));
      seed = lfsr(seed);
      m_ref[b] = int'(seed[6:0]);
      ctl.mwr(CBT_ADDR_CMD_REF, {1'b0, seed[6:0]});
    end
    #1;
    chk("ref", 16'(m_ref[0]), 16'(cref));
    @(posedge clk_sys_in);
    ctl.mwr(CBT_ADDR_MODE_CTRL, 8'h41);
    ctl.cke_out <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk("training", 16'(1), 16'(training));
    chk("bank", 16'(1), 16'(bank));
    chk("ref", 16'(m_ref[1]), 16'(cref));
    chk("oe_n", 16'h00ff, {2'b00, drv.oe_n[13:0]});
    @(posedge clk_sys_in);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      ctl.cs_out <= ~i[0];
      ctl.cmd_addr_out <= seed[5:0];
      if (!i[0]) begin
        m_echo = seed[5:0];
      end
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk("echo", 16'(m_echo), 16'(drv.data[13:8]));
      @(posedge clk_sys_in);
    end
    ctl.cs_out <= 1'b0;
    repeat (2) begin
      seed = lfsr(seed);
      codes.push_back(int'(seed[6:0]));
      ctl.vref(seed[6:0]);
      #1;
      chk("ref", 16'(codes.pop_front()), 16'(cref));
      @(posedge clk_sys_in);
    end
    ctl.cke_out <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    chk("training", 16'(0), 16'(training));
    chk("bank", 16'(0), 16'(bank));
    chk("ref", 16'(m_ref[0]), 16'(cref));
    repeat (10) @(posedge clk_sys_in);
    ctl.mwr(CBT_ADDR_MODE_CTRL, 8'h40);
    #1;
    chk("ready", 16'(0), 16'(ready));
    chk("mode", 16'h0040, 16'(mode));
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk("ready", 16'(1), 16'(ready));
    @(posedge clk_sys_in);
    ctl.mwr(CBT_ADDR_MODE_CTRL, 8'hc0);
    #1;
    chk("bank", 16'(1), 16'(bank));
    chk("ref", 16'(m_ref[1]), 16'(cref));
    @(posedge clk_sys_in);
    ctl.mwr(CBT_ADDR_CMD_REF, {1'b0, seed[6:0]});
    m_ref[1] = int'(seed[6:0]);
    #1;
    chk("ref", 16'(m_ref[1]), 16'(cref));
    @(posedge clk_sys_in);
    ctl.cke_out <= 1'b0;
    @(posedge clk_sys_in);
    ctl.mwr(CBT_ADDR_MODE_CTRL, 8'h41);
    repeat (4) @(posedge clk_sys_in);
    #1;
    chk("training", 16'(0), 16'(training));
    finish_test();
  end
endmodule
`default_nettype wire
